// File: cpu_bitops_pkg.sv
package cpu_bitops_pkg;

	// ----------------------------------------------------------------
	// operations handled by this unit
	// ----------------------------------------------------------------
	typedef enum logic [4:0] {
		nop_op,
		io_in_op,
		io_out_op,
		push_op,
		pop_op,
		ram_exchange_op,
		ram_load_or_op,
		ram_load_andnot_op,
		ram_load_xor_op,
		shift_left_op,
		shift_right_op,
		rotate_left_carry_op,
		rotate_right_carry_op,
		arith_right_op,
		nibble_swap_op,
		flag_set_op,
		flag_clear_op,
		io_bit_one_op,
		io_bit_zero_op,
		bit_to_tflag_op,
		tflag_to_bit_op,
		program_store_op,
		break_op,
		sleep_op,
		watchdog_kick_op
	} op_t;

	// ----------------------------------------------------------------
	// status flag positions, reset values, counts
	// ----------------------------------------------------------------
	localparam logic [2:0] FLAG_C = 3'h0;
	localparam logic [2:0] FLAG_Z = 3'h1;
	localparam logic [2:0] FLAG_N = 3'h2;
	localparam logic [2:0] FLAG_V = 3'h3;
	localparam logic [2:0] FLAG_S = 3'h4;
	localparam logic [2:0] FLAG_H = 3'h5;
	localparam logic [2:0] FLAG_T = 3'h6;
	localparam logic [2:0] FLAG_I = 3'h7;
	localparam logic [7:0] FLAGS_RESET = 8'h00;
	localparam logic [15:0] SP_RESET = 16'hffff;
	localparam logic [7:0] EXT_RESET = 8'h00;
	localparam logic [4:0] Z_LOW_IDX = 5'h1e;
	localparam logic [4:0] Z_HIGH_IDX = 5'h1f;
	localparam logic [15:0] PROG_STEP = 16'h0002;
	localparam int MEM_OP_CYCLES = 2;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		op_t op;
		logic [4:0] reg_idx;
		logic [2:0] bit_sel;
		logic [5:0] io_addr;
		logic extra_wait;
	} cmd_t;

	typedef struct packed {
		logic re;
		logic we;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mem_req_t;

	typedef struct packed {
		logic we;
		logic [5:0] addr;
		logic [7:0] wdata;
	} io_req_t;

	typedef struct packed {
		logic we;
		logic [23:0] addr;
		logic [15:0] wdata;
	} prog_req_t;

endpackage

// File: cpu_bitops_unit.sv
module cpu_bitops_unit (
	// clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	// instruction
	input wire logic cmd_valid_i,
	input wire cpu_bitops_pkg::cmd_t cmd_i,
	output logic ready_o,
	output logic done_o,
	// data memory
	output cpu_bitops_pkg::mem_req_t mem_req_o,
	input wire logic [7:0] mem_rdata_i,
	input wire logic mem_ack_i,
	input wire logic ext_ram_i,
	// io space
	output cpu_bitops_pkg::io_req_t io_req_o,
	input wire logic [7:0] io_rdata_i,
	// program memory
	output cpu_bitops_pkg::prog_req_t prog_req_o,
	// register file and pointer access
	input wire logic reg_wr_en_i,
	input wire logic [4:0] reg_wr_idx_i,
	input wire logic [7:0] reg_wr_data_i,
	input wire logic [4:0] reg_rd_idx_i,
	output logic [7:0] reg_rd_data_o,
	input wire logic ext_wr_en_i,
	input wire logic [7:0] ext_wr_data_i,
	// state and control pulses
	output logic [7:0] status_flags_o,
	output logic [15:0] stack_ptr_o,
	output logic break_o,
	output logic sleep_o,
	output logic watchdog_kick_o
);
	import cpu_bitops_pkg::*;

	typedef enum logic [2:0] {
		st_idle = 3'b001,
		st_wait = 3'b010,
		st_read = 3'b100
	} state_t;

	// ----------------------------------------------------------------
	// storage
	// ----------------------------------------------------------------
	logic [7:0] rf_reg [32];
	logic [7:0] status_flags_reg, status_flags_next;
	logic [15:0] sp_reg, sp_next;
	logic [7:0] pointer_extension_reg;
	state_t state_reg, state_next;
	cmd_t pend_reg, pend_next;
	logic [7:0] pend_val_reg, pend_val_next;
	logic ready_reg, ready_next;
	logic done_reg, done_next;
	mem_req_t mem_req_reg, mem_req_next;
	io_req_t io_req_reg, io_req_next;
	prog_req_t prog_req_reg, prog_req_next;
	logic [7:0] reg_rd_data_reg;
	logic brk_reg, brk_next, slp_reg, slp_next, wdk_reg, wdk_next;

	function automatic logic [8:0] shift_unit(input op_t op,
		input logic [7:0] v, input logic c);
		case (op)
			shift_left_op: return {v[7], v[6:0], 1'b0};
			rotate_left_carry_op: return {v[7], v[6:0], c};
			shift_right_op: return {v[0], 1'b0, v[7:1]};
			rotate_right_carry_op: return {v[0], c, v[7:1]};
			arith_right_op: return {v[0], v[7], v[7:1]};
			default: return {c, v};
		endcase
	endfunction

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire logic take = cmd_valid_i && (state_reg == st_idle);
	wire logic [7:0] rd_val = rf_reg[cmd_i.reg_idx];
	wire logic [15:0] z_ptr = {rf_reg[Z_HIGH_IDX], rf_reg[Z_LOW_IDX]};
	wire logic [15:0] z_plus = z_ptr + PROG_STEP;
	wire logic [7:0] bit_mask = 8'h01 << cmd_i.bit_sel;
	wire logic [8:0] sh = shift_unit(cmd_i.op, rd_val,
		status_flags_reg[FLAG_C]);
	wire logic sh_n = sh[7];
	wire logic sh_v = sh[7] ^ sh[8];
	wire logic left_op = (cmd_i.op == shift_left_op) ||
		(cmd_i.op == rotate_left_carry_op);
	// external ram holds the read until it answers
	wire logic mem_ok = mem_ack_i || !ext_ram_i;

	logic rf_we, z_we;
	logic [4:0] rf_widx;
	logic [7:0] rf_wdata;

	always_comb begin
		status_flags_next = status_flags_reg;
		sp_next = sp_reg;
		state_next = state_reg;
		pend_next = pend_reg;
		pend_val_next = pend_val_reg;
		ready_next = ready_reg;
		done_next = 1'b0;
		mem_req_next = '0;
		io_req_next = '0;
		prog_req_next = '0;
		brk_next = 1'b0;
		slp_next = 1'b0;
		wdk_next = 1'b0;
		rf_we = 1'b0;
		rf_widx = cmd_i.reg_idx;
		rf_wdata = rd_val;
		z_we = 1'b0;
		case (state_reg)
			st_idle: begin
				ready_next = 1'b1;
				if (cmd_valid_i) begin
					done_next = 1'b1;
					case (cmd_i.op)
						io_in_op: begin
							rf_we = 1'b1;
							rf_wdata = io_rdata_i;
						end
						io_out_op: begin
							io_req_next = '{1'b1, cmd_i.io_addr, rd_val};
						end
						push_op: begin
							mem_req_next = '{1'b0, 1'b1, sp_reg, rd_val};
							sp_next = sp_reg - 16'h0001;
						end
						pop_op, ram_exchange_op, ram_load_or_op,
						ram_load_andnot_op, ram_load_xor_op: begin
							done_next = 1'b0;
							ready_next = 1'b0;
							pend_next = cmd_i;
							pend_val_next = rd_val;
							state_next = cmd_i.extra_wait ? st_wait : st_read;
							if (cmd_i.op == pop_op) begin
								sp_next = sp_reg + 16'h0001;
								mem_req_next = '{1'b1, 1'b0, sp_reg + 16'h0001, 8'h00};
							end else begin
								mem_req_next = '{1'b1, 1'b0, z_ptr, 8'h00};
							end
						end
						shift_left_op, shift_right_op, rotate_left_carry_op,
						rotate_right_carry_op, arith_right_op: begin
							rf_we = 1'b1;
							rf_wdata = sh[7:0];
							status_flags_next[FLAG_C] = sh[8];
							status_flags_next[FLAG_Z] = (sh[7:0] == 8'h00);
							status_flags_next[FLAG_N] = sh_n;
							// shifts leave S alone
							status_flags_next[FLAG_V] = sh_v;
							if (left_op)
								status_flags_next[FLAG_H] = rd_val[3];
						end
						nibble_swap_op: begin
							rf_we = 1'b1;
							rf_wdata = {rd_val[3:0], rd_val[7:4]};
						end
						// one flag per op, chosen by bit_sel
						flag_set_op: begin
							status_flags_next = status_flags_reg | bit_mask;
						end
						flag_clear_op: begin
							status_flags_next = status_flags_reg & ~bit_mask;
						end
						io_bit_one_op: begin
							io_req_next = '{1'b1, cmd_i.io_addr, io_rdata_i | bit_mask};
						end
						io_bit_zero_op: begin
							io_req_next = '{1'b1, cmd_i.io_addr, io_rdata_i & ~bit_mask};
						end
						bit_to_tflag_op: begin
							status_flags_next[FLAG_T] = rd_val[cmd_i.bit_sel];
						end
						tflag_to_bit_op: begin
							rf_we = 1'b1;
							rf_wdata = status_flags_reg[FLAG_T] ?
								(rd_val | bit_mask) : (rd_val & ~bit_mask);
						end
						program_store_op: begin
							prog_req_next = '{1'b1, {pointer_extension_reg, z_ptr},
								{rf_reg[5'h01], rf_reg[5'h00]}};
							z_we = 1'b1;
						end
						break_op: brk_next = 1'b1;
						sleep_op: slp_next = 1'b1;
						watchdog_kick_op: wdk_next = 1'b1;
						default: begin
						end
					endcase
				end
			end
			st_wait: begin
				// the extra internal-sram cycle, request held
				mem_req_next = mem_req_reg;
				state_next = st_read;
			end
			st_read: begin
				mem_req_next = mem_req_reg;
				if (mem_ok) begin
					done_next = 1'b1;
					ready_next = 1'b1;
					state_next = st_idle;
					rf_we = 1'b1;
					rf_widx = pend_reg.reg_idx;
					rf_wdata = mem_rdata_i;
					mem_req_next.re = 1'b0;
					mem_req_next.we = (pend_reg.op != pop_op);
					case (pend_reg.op)
						ram_exchange_op: mem_req_next.wdata = pend_val_reg;
						ram_load_or_op:
							mem_req_next.wdata = pend_val_reg | mem_rdata_i;
						ram_load_andnot_op:
							mem_req_next.wdata = mem_rdata_i & ~pend_val_reg;
						ram_load_xor_op:
							mem_req_next.wdata = pend_val_reg ^ mem_rdata_i;
						default: mem_req_next.wdata = 8'h00;
					endcase
				end
			end
			default: begin
				state_next = st_idle;
				ready_next = 1'b1;
			end
		endcase
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	// instruction results win over the side write port
	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 32; i++)
				rf_reg[i] <= 8'h00;
		end else begin
			if (reg_wr_en_i)
				rf_reg[reg_wr_idx_i] <= reg_wr_data_i;
			if (z_we) begin
				rf_reg[Z_LOW_IDX] <= z_plus[7:0];
				rf_reg[Z_HIGH_IDX] <= z_plus[15:8];
			end
			if (rf_we)
				rf_reg[rf_widx] <= rf_wdata;
		end
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			status_flags_reg <= FLAGS_RESET;
			sp_reg <= SP_RESET;
			pointer_extension_reg <= EXT_RESET;
			state_reg <= st_idle;
			pend_reg <= '0;
			pend_val_reg <= 8'h00;
			ready_reg <= 1'b0;
			done_reg <= 1'b0;
			mem_req_reg <= '0;
			io_req_reg <= '0;
			prog_req_reg <= '0;
			reg_rd_data_reg <= 8'h00;
			brk_reg <= 1'b0;
			slp_reg <= 1'b0;
			wdk_reg <= 1'b0;
		end else begin
			status_flags_reg <= status_flags_next;
			sp_reg <= sp_next;
			if (ext_wr_en_i)
				pointer_extension_reg <= ext_wr_data_i;
			state_reg <= state_next;
			pend_reg <= pend_next;
			pend_val_reg <= pend_val_next;
			ready_reg <= ready_next;
			done_reg <= done_next;
			mem_req_reg <= mem_req_next;
			io_req_reg <= io_req_next;
			prog_req_reg <= prog_req_next;
			reg_rd_data_reg <= rf_reg[reg_rd_idx_i];
			brk_reg <= brk_next;
			slp_reg <= slp_next;
			wdk_reg <= wdk_next;
		end
	end

	assign ready_o = ready_reg;
	assign done_o = done_reg;
	assign mem_req_o = mem_req_reg;
	assign io_req_o = io_req_reg;
	assign prog_req_o = prog_req_reg;
	assign reg_rd_data_o = reg_rd_data_reg;
	assign status_flags_o = status_flags_reg;
	assign stack_ptr_o = sp_reg;
	assign break_o = brk_reg;
	assign sleep_o = slp_reg;
	assign watchdog_kick_o = wdk_reg;

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_prog_store_step: assert property (
		take && cmd_i.op == program_store_op && !reg_wr_en_i |=>
		prog_req_o.we && prog_req_o.addr[15:0] == $past(z_ptr) &&
		z_ptr == $past(z_ptr) + PROG_STEP &&
		status_flags_o == $past(status_flags_o))
		else $error("program store pointer step wrong");
	a_io_in_flags: assert property (
		take && cmd_i.op == io_in_op |=> done_o && ready_o &&
		status_flags_o == $past(status_flags_o))
		else $error("io in not single cycle or flags moved");
	a_push_stack_write: assert property (
		take && cmd_i.op == push_op |=> mem_req_o.we && done_o &&
		mem_req_o.addr == $past(stack_ptr_o) &&
		stack_ptr_o == $past(stack_ptr_o) - 16'h0001)
		else $error("push write or pointer wrong");
	a_pop_two_cycles: assert property (
		take && cmd_i.op == pop_op && !cmd_i.extra_wait ##1 !ext_ram_i
		|-> !done_o ##1 done_o && !mem_req_o.we)
		else $error("pop not done in two cycles");
	a_load_or_data: assert property (
		take && cmd_i.op == ram_load_or_op && !cmd_i.extra_wait
		##1 !ext_ram_i |=> mem_req_o.we &&
		mem_req_o.wdata == ($past(rd_val, 2) | $past(mem_rdata_i)))
		else $error("load-or writeback wrong");
	a_load_andnot_data: assert property (
		take && cmd_i.op == ram_load_andnot_op && !cmd_i.extra_wait
		##1 !ext_ram_i |=> mem_req_o.we &&
		mem_req_o.wdata == ($past(mem_rdata_i) & ~$past(rd_val, 2)))
		else $error("load-andnot writeback wrong");
	a_rotate_left_carry: assert property (
		take && cmd_i.op == rotate_left_carry_op |=>
		status_flags_o[FLAG_C] == $past(rd_val[7]) &&
		status_flags_o[FLAG_H] == $past(rd_val[3]))
		else $error("rotate left carry or half carry wrong");
	a_rotate_right_h: assert property (
		take && cmd_i.op == rotate_right_carry_op |=>
		status_flags_o[FLAG_C] == $past(rd_val[0]) &&
		status_flags_o[FLAG_H] == $past(status_flags_o[FLAG_H]) &&
		status_flags_o[FLAG_S] == $past(status_flags_o[FLAG_S]))
		else $error("rotate right flags wrong");
	a_io_bit_one: assert property (
		take && cmd_i.op == io_bit_one_op |=> io_req_o.we &&
		io_req_o.wdata == ($past(io_rdata_i) | $past(bit_mask)))
		else $error("io bit one value wrong");
	a_bit_to_tflag: assert property (
		take && cmd_i.op == bit_to_tflag_op |=>
		status_flags_o[FLAG_T] == $past(rd_val[cmd_i.bit_sel]) &&
		status_flags_o[5:0] == $past(status_flags_o[5:0]))
		else $error("bit to T wrong");
	a_flag_set_one: assert property (
		take && cmd_i.op == flag_set_op |=>
		status_flags_o == ($past(status_flags_o) | $past(bit_mask)))
		else $error("flag set touched other flags");
	a_control_pulse: assert property (
		take && cmd_i.op == watchdog_kick_op |=> watchdog_kick_o &&
		done_o ##1 !watchdog_kick_o)
		else $error("watchdog kick not a single pulse");

	c_pop_done: cover property (
		take && cmd_i.op == pop_op ##[1:4] done_o);
	c_pop_stretched: cover property (
		take && cmd_i.op == pop_op ##1 ext_ram_i && !mem_ack_i);
	c_sleep: cover property (take && cmd_i.op == sleep_op);

endmodule

// File: cpu_bitops_far_model.sv
module cpu_bitops_far_model #(
	parameter int SLOW_WAIT = 3
) (
	// clock
	input wire logic clk_i,
	// data memory
	input wire cpu_bitops_pkg::mem_req_t mem_req_i,
	input wire logic slow_i,
	output logic [7:0] mem_rdata_o,
	output logic mem_ack_o,
	// io space and program memory
	input wire logic [5:0] io_sel_i,
	input wire cpu_bitops_pkg::io_req_t io_req_i,
	output logic [7:0] io_rdata_o,
	input wire cpu_bitops_pkg::prog_req_t prog_req_i
);
	timeunit 1ns;
	timeprecision 1ns;
	import cpu_bitops_pkg::*;
	logic [7:0] mem [0:65535];
	logic [7:0] io [0:63];
	logic [7:0] last_rd = 8'h00;
	int wait_cnt = 0;
	logic [23:0] prog_addr;
	logic [15:0] prog_data;
	always @(posedge clk_i) begin
		if (mem_req_i.we)
			mem[mem_req_i.addr] <= mem_req_i.wdata;
		if (mem_req_i.re)
			last_rd <= mem_rdata_o;
		// external ram answers late to stretch the access
		wait_cnt <= (mem_req_i.re && slow_i) ? wait_cnt + 1 : 0;
		if (io_req_i.we)
			io[io_req_i.addr] <= io_req_i.wdata;
		if (prog_req_i.we) begin
			prog_addr <= prog_req_i.addr;
			prog_data <= prog_req_i.wdata;
		end
	end
	// idle read bus shows junk, never the last byte
	assign mem_rdata_o = mem_req_i.re ? mem[mem_req_i.addr] : ~last_rd;
	assign mem_ack_o = !slow_i || (wait_cnt >= SLOW_WAIT);
	assign io_rdata_o = io[io_sel_i];
endmodule

// File: cpu_data_bit_control_instr_tb.sv
module cpu_data_bit_control_instr_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import cpu_bitops_pkg::*;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic cmd_valid = 1'b0;
	cmd_t cmd = '0;
	logic ready_o, done_o, break_o, sleep_o, watchdog_kick_o;
	mem_req_t mem_req_o;
	io_req_t io_req_o;
	prog_req_t prog_req_o;
	logic [7:0] mem_rdata, io_rdata, reg_rd_data_o, status_flags_o;
	logic mem_ack;
	logic ext_ram = 1'b0;
	logic wr_en = 1'b0;
	logic [4:0] wr_idx = '0;
	logic [7:0] wr_data = '0;
	logic [4:0] rd_idx = '0;
	logic ext_en = 1'b0;
	logic [7:0] ext_data = '0;
	logic [15:0] stack_ptr_o;
	int err_total = 0;
	int check_count = 0;
	int cyc = 0;
	int last_n;
	logic [7:0] ef, v;
	logic [15:0] sx;
	op_t rops [4] = '{ram_load_or_op, ram_load_andnot_op,
		ram_load_xor_op, ram_exchange_op};
	logic [7:0] rexp [4] = '{8'hdb, 8'h18, 8'h99, 8'hc3};
	op_t sops [6] = '{rotate_left_carry_op, rotate_right_carry_op,
		shift_left_op, shift_right_op, arith_right_op, nibble_swap_op};
	op_t mops [3] = '{break_op, sleep_op, watchdog_kick_op};

	initial begin
		forever #4 clk_i = ~clk_i;
	end

	cpu_bitops_unit i_cpu_bitops_unit (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.cmd_valid_i(cmd_valid), .cmd_i(cmd), .ready_o(ready_o),
		.done_o(done_o), .mem_req_o(mem_req_o), .mem_rdata_i(mem_rdata),
		.mem_ack_i(mem_ack), .ext_ram_i(ext_ram), .io_req_o(io_req_o),
		.io_rdata_i(io_rdata), .prog_req_o(prog_req_o),
		.reg_wr_en_i(wr_en), .reg_wr_idx_i(wr_idx),
		.reg_wr_data_i(wr_data), .reg_rd_idx_i(rd_idx),
		.reg_rd_data_o(reg_rd_data_o), .ext_wr_en_i(ext_en),
		.ext_wr_data_i(ext_data), .status_flags_o(status_flags_o),
		.stack_ptr_o(stack_ptr_o), .break_o(break_o), .sleep_o(sleep_o),
		.watchdog_kick_o(watchdog_kick_o));

	cpu_bitops_far_model i_cpu_bitops_far_model (.clk_i(clk_i),
		.mem_req_i(mem_req_o), .slow_i(ext_ram), .mem_rdata_o(mem_rdata),
		.mem_ack_o(mem_ack), .io_sel_i(cmd.io_addr), .io_req_i(io_req_o),
		.io_rdata_o(io_rdata), .prog_req_i(prog_req_o));

	// ----------------------------------------------------------------
	// access tasks
	// ----------------------------------------------------------------
	task automatic test_done();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tick();
		@(posedge clk_i);
		#1;
	endtask

	task automatic wr_reg(input logic [4:0] idx, input logic [7:0] val);
		tick();
		wr_en = 1'b1;
		wr_idx = idx;
		wr_data = val;
		tick();
		wr_en = 1'b0;
	endtask

	task automatic rd_reg(input logic [4:0] idx, output logic [7:0] val);
		tick();
		rd_idx = idx;
		tick();
		val = reg_rd_data_o;
	endtask

	// exp_n of zero skips the cycle count check
	task automatic exec(input op_t op, input logic [4:0] r,
		input logic [2:0] b, input logic [5:0] a, input logic xw,
		input int exp_n);
		tick();
		cmd = '{op, r, b, a, xw};
		cmd_valid = 1'b1;
		last_n = 0;
		while (ready_o !== 1'b1 && last_n < 50) begin
			tick();
			last_n++;
		end
		tick();
		cmd_valid = 1'b0;
		last_n = 1;
		while (done_o !== 1'b1 && last_n < 50) begin
			tick();
			last_n++;
		end
		if (exp_n != 0)
			chk(24'(last_n), 24'(exp_n));
	endtask

	function automatic logic [15:0] shift_exp(op_t op, logic [7:0] v,
		logic [7:0] f);
		logic [7:0] res;
		logic co;
		res = {v[3:0], v[7:4]};
		co = f[FLAG_C];
		case (op)
			rotate_left_carry_op: {co, res} = {v, f[FLAG_C]};
			shift_left_op: {co, res} = {v, 1'b0};
			rotate_right_carry_op: {res, co} = {f[FLAG_C], v};
			shift_right_op: {res, co} = {1'b0, v};
			arith_right_op: {res, co} = {v[7], v};
			default: return {res, f};
		endcase
		f[FLAG_C] = co;
		f[FLAG_N] = res[7];
		f[FLAG_V] = res[7] ^ co;
		f[FLAG_Z] = (res == 8'h00);
		if (op == rotate_left_carry_op || op == shift_left_op)
			f[FLAG_H] = v[3];
		return {res, f};
	endfunction

	// hang guard, the sequence needs well under a thousand cycles
	always @(posedge clk_i) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			test_done();
		end
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (8) @(posedge clk_i);
		#1;
		rst_n_i = 1'b1;
		tick();
		chk(24'(status_flags_o), 24'(FLAGS_RESET));
		chk(24'(stack_ptr_o), 24'(SP_RESET));
		chk(24'(ready_o), 24'h1);
		ef = FLAGS_RESET;
		i_cpu_bitops_far_model.io[5] = 8'ha5;
		exec(io_in_op, 5'h03, 3'h0, 6'h05, 1'b0, 1);
		rd_reg(5'h03, v);
		chk(24'(v), 24'ha5);
		exec(io_out_op, 5'h03, 3'h0, 6'h09, 1'b0, 1);
		exec(io_bit_one_op, 5'h00, 3'h1, 6'h09, 1'b0, 1);
		tick();
		chk(24'(i_cpu_bitops_far_model.io[9]), 24'ha7);
		exec(io_bit_zero_op, 5'h00, 3'h7, 6'h09, 1'b0, 1);
		tick();
		chk(24'(i_cpu_bitops_far_model.io[9]), 24'h27);
		chk(24'(status_flags_o), 24'(ef));
		// stack: plain, internal sram wait, external ram
		wr_reg(5'h04, 8'h3c);
		for (int k = 0; k < 3; k++) begin
			exec(push_op, 5'h04, 3'h0, 6'h00, 1'b0, 1);
			chk(24'(stack_ptr_o), 24'hfffe);
			tick();
			chk(24'(i_cpu_bitops_far_model.mem[16'hffff]), 24'h3c);
			ext_ram = (k == 2);
			// external ram: two cycles plus the model's three waits
			exec(pop_op, 5'(6 + k), 3'h0, 6'h00, k == 1,
				(k == 2) ? 5 : 2 + k);
			ext_ram = 1'b0;
			chk(24'(stack_ptr_o), 24'hffff);
			rd_reg(5'(6 + k), v);
			chk(24'(v), 24'h3c);
		end
		// read-modify-write at Z
		wr_reg(5'h1e, 8'h20);
		wr_reg(5'h1f, 8'h01);
		for (int k = 0; k < 4; k++) begin
			i_cpu_bitops_far_model.mem[16'h0120] = 8'h5a;
			wr_reg(5'h09, 8'hc3);
			exec(rops[k], 5'h09, 3'h0, 6'h00, 1'b0, 2);
			tick();
			chk(24'(i_cpu_bitops_far_model.mem[16'h0120]), 24'(rexp[k]));
			rd_reg(5'h09, v);
			chk(24'(v), 24'h5a);
			chk(24'(status_flags_o), 24'(ef));
		end
		// shifts and nibble swap, carry in taken from the previous step
		for (int k = 0; k < 12; k++) begin
			v = (k % 2) ? 8'h01 : 8'h88;
			wr_reg(5'h0a, v);
			exec(sops[k / 2], 5'h0a, 3'h0, 6'h00, 1'b0, 1);
			sx = shift_exp(sops[k / 2], v, ef);
			ef = sx[7:0];
			rd_reg(5'h0a, v);
			chk(24'(v), 24'(sx[15:8]));
			chk(24'(status_flags_o), 24'(ef));
		end
		for (int k = 0; k < 16; k++) begin
			exec(k % 2 ? flag_clear_op : flag_set_op, 5'h00, 3'(k / 2),
				6'h00, 1'b0, 1);
			ef[k / 2] = !(k % 2);
			chk(24'(status_flags_o), 24'(ef));
		end
		// T flag transfers
		wr_reg(5'h0b, 8'h10);
		wr_reg(5'h0c, 8'h00);
		exec(bit_to_tflag_op, 5'h0b, 3'h4, 6'h00, 1'b0, 1);
		ef[FLAG_T] = 1'b1;
		chk(24'(status_flags_o), 24'(ef));
		exec(tflag_to_bit_op, 5'h0c, 3'h2, 6'h00, 1'b0, 1);
		rd_reg(5'h0c, v);
		chk(24'(v), 24'h04);
		exec(bit_to_tflag_op, 5'h0b, 3'h3, 6'h00, 1'b0, 1);
		ef[FLAG_T] = 1'b0;
		exec(tflag_to_bit_op, 5'h0b, 3'h4, 6'h00, 1'b0, 1);
		rd_reg(5'h0b, v);
		chk(24'(v), 24'h00);
		chk(24'(status_flags_o), 24'(ef));
		// program store with byte carry in Z
		wr_reg(5'h00, 8'h34);
		wr_reg(5'h01, 8'h12);
		wr_reg(5'h1e, 8'hfe);
		wr_reg(5'h1f, 8'h10);
		tick();
		ext_en = 1'b1;
		ext_data = 8'h05;
		tick();
		ext_en = 1'b0;
		exec(program_store_op, 5'h00, 3'h0, 6'h00, 1'b0, 1);
		tick();
		chk(i_cpu_bitops_far_model.prog_addr, 24'h0510fe);
		chk(24'(i_cpu_bitops_far_model.prog_data), 24'h1234);
		rd_reg(5'h1e, v);
		chk(24'(v), 24'h00);
		rd_reg(5'h1f, v);
		chk(24'(v), 24'h11);
		for (int k = 0; k < 3; k++) begin
			exec(mops[k], 5'h00, 3'h0, 6'h00, 1'b0, 1);
			chk(24'({break_o, sleep_o, watchdog_kick_o}),
				24'(3'h4 >> k));
			chk(24'(status_flags_o), 24'(ef));
		end
		test_done();
	end
endmodule
